// ### tcs_top.sv
`timescale 1ns/1ps
// How it works
// - each circuit is supervised with one input or with two inputs.
// - missing input routing for the chosen mode flags a per-circuit mismatch alarm.
// - up to three circuits, one per breaker pole, each supervised independently.
// - inputs read high energised, low shorted; H/L, H/H, L/H are normal.
// - two-input mode: both inputs low is the abnormal condition.
// - two-input mode samples both inputs every 500 ms.
// - two-input alarm rises after three consecutive abnormal checks.
// - two-input alarm clears after the same debounce once normal.
// - two-input delay is fixed, about one to one and a half seconds.
// - one-input mode: high is normal, low only expected while tripping.
// - one-input alarm when input stays low longer than the set delay.
// - one-input alarm clears after the same delay once high again.
// - a short trip contact closure gives no alarm.
// - detection is suspended while a system fault is handled.
// - enable setting on or off, default off; off stops supervision.
// - inputs-per-circuit setting selects one or two, default two.
// - one-input delay ranges 1 to 30 seconds, default 2 seconds.
module tcs_top
  import tcs_pkg::*;
#(
  parameter int TICK_CYCLES = TCS_CHECK_CYC
)
(
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic resetn_i,
  // apb slave
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  // binary inputs, asynchronous
  input wire logic [2:0] trip_side_input_i,
  input wire logic [2:0] breaker_side_input_i,
  input wire logic system_fault_i,
  // indications
  output logic [2:0] trip_fail_o,
  output logic [2:0] routing_mismatch_alarm_o,
  output logic supervision_off_o,
  output logic irq_o
);
  typedef struct packed {
    logic [2:0] trip_m;
    logic [2:0] trip_s;
    logic [2:0] brk_m;
    logic [2:0] brk_s;
    logic fault_m;
    logic fault_s;
    logic [23:0] tick_cnt;
    logic tick;
    logic supervision_enable;
    logic two_inputs;
    logic [4:0] delay_s;
    logic [1:0] circuits;
    logic [2:0] route_trip;
    logic [2:0] route_brk;
    logic [5:0] istat;
    logic [5:0] imask;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
    logic [2:0] fail;
    logic [2:0] mism;
    logic off;
    logic irq;
  } tcs_top_st_t;

  tcs_top_st_t s_r;
  tcs_top_st_t s_nxt;
  logic [2:0] chan_alarm;
  logic [2:0] chan_run;
  logic [2:0] mism_now;

  // decodes a register offset to a hit
  function automatic logic addr_hit(input logic [11:0] a, input logic [11:0] ofs);
    addr_hit = (a == ofs);
  endfunction : addr_hit

  // clamps a delay write into the legal range
  function automatic logic [4:0] clamp_delay(input logic [4:0] d);
    if (d < TCS_DELAY_MIN_S)
      clamp_delay = TCS_DELAY_MIN_S;
    else if (d > TCS_DELAY_MAX_S)
      clamp_delay = TCS_DELAY_MAX_S;
    else
      clamp_delay = d;
  endfunction : clamp_delay

  genvar gi;
  generate
    for (gi = 0; gi < TCS_NCIRC; gi++)
    begin : g_circ
      logic used;
      assign used = (2'(gi) < s_r.circuits);
      // a circuit lacking its inputs is blocked, not supervised
      assign mism_now[gi] = s_r.supervision_enable && used &&
        (!s_r.route_trip[gi] || (s_r.two_inputs && !s_r.route_brk[gi]));
      assign chan_run[gi] = s_r.supervision_enable && used && !mism_now[gi];

      tcs_chan u_chan (
        .ref_clk_i(ref_clk_i),
        .resetn_i(resetn_i),
        .run_i(chan_run[gi]),
        .two_in_i(s_r.two_inputs),
        .delay_s_i(s_r.delay_s),
        .fault_i(s_r.fault_s),
        .tick_i(s_r.tick),
        .trip_side_input_i(s_r.trip_s[gi]),
        .breaker_side_input_i(s_r.brk_s[gi]),
        .alarm_o(chan_alarm[gi])
      );
    end
  endgenerate

  always_comb
  begin
    logic setup;
    logic done;
    logic [5:0] ev;
    logic [5:0] clr;
    logic [31:0] rd;
    logic hit;
    setup = 1'b0;
    done = 1'b0;
    ev = '0;
    clr = '0;
    rd = 32'h0000_0000;
    hit = 1'b0;
    s_nxt = s_r;

    // pins pass two flops before use
    s_nxt.trip_m = trip_side_input_i;
    s_nxt.trip_s = s_r.trip_m;
    s_nxt.brk_m = breaker_side_input_i;
    s_nxt.brk_s = s_r.brk_m;
    s_nxt.fault_m = system_fault_i;
    s_nxt.fault_s = s_r.fault_m;

    // periodic check tick; held in reset while off so timing restarts cleanly
    s_nxt.tick = 1'b0;
    if (!s_r.supervision_enable)
    begin
      s_nxt.tick_cnt = 24'h00_0000;
    end
    else if (s_r.tick_cnt >= 24'(TICK_CYCLES - 1))
    begin
      s_nxt.tick_cnt = 24'h00_0000;
      s_nxt.tick = 1'b1;
    end
    else
    begin
      s_nxt.tick_cnt = s_r.tick_cnt + 24'h00_0001;
    end

    // apb: one wait-free access phase, answered from a flop
    setup = psel_i && !penable_i;
    done = psel_i && penable_i && s_r.pready;
    s_nxt.pready = setup;
    if (setup)
    begin
      hit = addr_hit(paddr_i, TCS_OFS_CTRL) || addr_hit(paddr_i, TCS_OFS_ROUTE) ||
        addr_hit(paddr_i, TCS_OFS_STATUS) || addr_hit(paddr_i, TCS_OFS_ISTAT) ||
        addr_hit(paddr_i, TCS_OFS_IMASK);
      if (addr_hit(paddr_i, TCS_OFS_CTRL))
      begin
        rd[TCS_CTRL_EN_BIT] = s_r.supervision_enable;
        rd[TCS_CTRL_TWO_BIT] = s_r.two_inputs;
        rd[TCS_CTRL_DLY_LSB +: 5] = s_r.delay_s;
        rd[TCS_CTRL_NC_LSB +: 2] = s_r.circuits;
      end
      else if (addr_hit(paddr_i, TCS_OFS_ROUTE))
      begin
        rd[2:0] = s_r.route_trip;
        rd[TCS_ROUTE_BRK_LSB +: 3] = s_r.route_brk;
      end
      else if (addr_hit(paddr_i, TCS_OFS_STATUS))
      begin
        rd[2:0] = s_r.fail;
        rd[TCS_ST_MIS_LSB +: 3] = s_r.mism;
        rd[TCS_ST_OFF_BIT] = s_r.off;
      end
      else if (addr_hit(paddr_i, TCS_OFS_ISTAT))
      begin
        rd[5:0] = s_r.istat;
      end
      else if (addr_hit(paddr_i, TCS_OFS_IMASK))
      begin
        rd[5:0] = s_r.imask;
      end
      s_nxt.prdata = rd;
      s_nxt.pslverr = !hit;
    end
    else if (done)
    begin
      s_nxt.pslverr = 1'b0;
    end

    if (done && pwrite_i && !s_r.pslverr)
    begin
      if (addr_hit(paddr_i, TCS_OFS_CTRL))
      begin
        s_nxt.supervision_enable = pwdata_i[TCS_CTRL_EN_BIT];
        s_nxt.two_inputs = pwdata_i[TCS_CTRL_TWO_BIT];
        s_nxt.delay_s = clamp_delay(pwdata_i[TCS_CTRL_DLY_LSB +: 5]);
        s_nxt.circuits = pwdata_i[TCS_CTRL_NC_LSB +: 2];
      end
      if (addr_hit(paddr_i, TCS_OFS_ROUTE))
      begin
        s_nxt.route_trip = pwdata_i[2:0];
        s_nxt.route_brk = pwdata_i[TCS_ROUTE_BRK_LSB +: 3];
      end
      if (addr_hit(paddr_i, TCS_OFS_ISTAT))
      begin
        clr = pwdata_i[5:0];
      end
      if (addr_hit(paddr_i, TCS_OFS_IMASK))
      begin
        s_nxt.imask = pwdata_i[5:0];
      end
    end

    // indications; events are rising alarms, and a new event beats a clear
    s_nxt.fail = chan_alarm;
    s_nxt.mism = mism_now;
    s_nxt.off = !s_r.supervision_enable;
    ev = {mism_now & ~s_r.mism, chan_alarm & ~s_r.fail};
    s_nxt.istat = (s_r.istat & ~clr) | ev;
    s_nxt.irq = |(s_nxt.istat & s_r.imask);
  end

  always_ff @(posedge ref_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      s_r <= '0;
      s_r.supervision_enable <= TCS_EN_RST;
      s_r.two_inputs <= TCS_TWO_RST;
      s_r.delay_s <= TCS_DELAY_RST_S;
      s_r.circuits <= TCS_NC_RST;
      s_r.off <= 1'b1;
    end
    else
    begin
      s_r <= s_nxt;
    end
  end

  assign prdata_o = s_r.prdata;
  assign pready_o = s_r.pready;
  assign pslverr_o = s_r.pslverr;
  assign trip_fail_o = s_r.fail;
  assign routing_mismatch_alarm_o = s_r.mism;
  assign supervision_off_o = s_r.off;
  assign irq_o = s_r.irq;

  mismatch_flag_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
    s_r.supervision_enable && s_r.circuits != 2'h0 && !s_r.route_trip[0] |=> routing_mismatch_alarm_o[0])
    else $error("missing routing not flagged");
  off_quiet_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
    !s_r.supervision_enable [*3] |-> trip_fail_o == 3'h0 && supervision_off_o)
    else $error("alarm while supervision off");
  tick_period_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
    s_r.tick |-> s_r.tick_cnt == 24'h00_0000 && $past(s_r.tick_cnt) == 24'(TICK_CYCLES - 1))
    else $error("check tick off period");
  delay_range_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
    s_r.delay_s >= TCS_DELAY_MIN_S && s_r.delay_s <= TCS_DELAY_MAX_S)
    else $error("alarm delay out of range");
  blocked_idle_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
    !chan_run[1] ##1 !chan_run[1] |=> !trip_fail_o[1])
    else $error("blocked circuit raised an alarm");
  function automatic logic clr_seen();
    clr_seen = psel_i && penable_i && pwrite_i && addr_hit(paddr_i, TCS_OFS_ISTAT);
  endfunction : clr_seen

  irq_level_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
    |(s_r.istat & s_r.imask) |=> irq_o || $past(clr_seen()))
    else $error("irq missing for unmasked status");

  fail_seen_c: cover property (@(posedge ref_clk_i) disable iff (!resetn_i) $rose(trip_fail_o[0]));
  fail_clr_c: cover property (@(posedge ref_clk_i) disable iff (!resetn_i) $fell(trip_fail_o[0]));
  mism_c: cover property (@(posedge ref_clk_i) disable iff (!resetn_i) $rose(routing_mismatch_alarm_o[2]));
  irq_c: cover property (@(posedge ref_clk_i) disable iff (!resetn_i) $rose(irq_o));
endmodule : tcs_top

// ### tcs_chan.sv
`timescale 1ns/1ps
package tcs_pkg;
  localparam int TCS_NCIRC = 3;
  localparam int TCS_CLK_HZ = 25_000_000;
  localparam int TCS_CHECK_MS = 500;
  localparam int TCS_CHECK_CYC = TCS_CHECK_MS * (TCS_CLK_HZ / 1000);
  localparam logic [5:0] TCS_TWO_IN_CHECKS = 6'h03;
  localparam logic [4:0] TCS_DELAY_MIN_S = 5'h01;
  localparam logic [4:0] TCS_DELAY_MAX_S = 5'h1E;
  localparam logic [4:0] TCS_DELAY_RST_S = 5'h02;
  localparam logic [11:0] TCS_OFS_CTRL = 12'h000;
  localparam logic [11:0] TCS_OFS_ROUTE = 12'h004;
  localparam logic [11:0] TCS_OFS_STATUS = 12'h008;
  localparam logic [11:0] TCS_OFS_ISTAT = 12'h00C;
  localparam logic [11:0] TCS_OFS_IMASK = 12'h010;
  localparam int TCS_CTRL_EN_BIT = 0;
  localparam int TCS_CTRL_TWO_BIT = 1;
  localparam int TCS_CTRL_DLY_LSB = 2;
  localparam int TCS_CTRL_NC_LSB = 8;
  localparam int TCS_ROUTE_BRK_LSB = 3;
  localparam int TCS_ST_MIS_LSB = 3;
  localparam int TCS_ST_OFF_BIT = 6;
  localparam logic TCS_EN_RST = 1'b0;
  localparam logic TCS_TWO_RST = 1'b1;
  localparam logic [1:0] TCS_NC_RST = 2'h1;
endpackage : tcs_pkg

module tcs_chan
  import tcs_pkg::*;
(
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic resetn_i,
  // control
  input wire logic run_i,
  input wire logic two_in_i,
  input wire logic [4:0] delay_s_i,
  input wire logic fault_i,
  input wire logic tick_i,
  // synchronised inputs
  input wire logic trip_side_input_i,
  input wire logic breaker_side_input_i,
  // result
  output logic alarm_o
);
  typedef struct packed {
    logic [5:0] cnt;
    logic alarm;
    logic two_q;
  } tcs_chan_st_t;

  tcs_chan_st_t s_r;
  tcs_chan_st_t s_nxt;

  always_comb
  begin
    logic abn;
    logic [5:0] lim;
    abn = 1'b0;
    lim = TCS_TWO_IN_CHECKS;
    s_nxt = s_r;
    if (two_in_i)
    begin
      abn = !trip_side_input_i && !breaker_side_input_i;
      lim = TCS_TWO_IN_CHECKS;
    end
    else
    begin
      abn = !trip_side_input_i;
      lim = {delay_s_i, 1'b0}; // checks are half a second apart
    end
    if (!run_i)
    begin
      s_nxt = '0;
    end
    else if (fault_i)
    begin
      // trip commands during a fault must not count toward an alarm
      s_nxt.cnt = 6'h00;
    end
    else if (two_in_i != s_r.two_q)
    begin
      // a count begun in one mode must not finish early against the other mode's limit
      s_nxt.cnt = 6'h00;
    end
    else if (tick_i)
    begin
      if (abn != s_r.alarm)
      begin
        if (s_r.cnt + 6'h01 >= lim)
        begin
          s_nxt.alarm = abn;
          s_nxt.cnt = 6'h00;
        end
        else
        begin
          s_nxt.cnt = s_r.cnt + 6'h01;
        end
      end
      else
      begin
        s_nxt.cnt = 6'h00;
      end
    end
    s_nxt.two_q = two_in_i;
  end

  always_ff @(posedge ref_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
      s_r <= '0;
    else
      s_r <= s_nxt;
  end

  assign alarm_o = s_r.alarm;

  alarm_on_tick_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
    $changed(s_r.alarm) && s_r.alarm |-> $past(tick_i) && $past(run_i) && !$past(fault_i))
    else $error("alarm rose without a check tick");
  off_clears_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
    !run_i |=> !s_r.alarm && s_r.cnt == 6'h00)
    else $error("disabled circuit kept state");
  fault_hold_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
    run_i && fault_i |=> $stable(s_r.alarm) && s_r.cnt == 6'h00)
    else $error("detection ran during a fault");
  two_in_needs3_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
    $rose(s_r.alarm) && $past(two_in_i) |-> $past(s_r.cnt) == 6'h02)
    else $error("two-input alarm without three checks");
endmodule : tcs_chan

// ### tcs_circ_model.sv
`timescale 1ns/1ps
module tcs_circ_model (
  // contact states per pole
  input wire logic [2:0] trip_closed_i,
  input wire logic [2:0] breaker_on_i,
  input wire logic [2:0] broken_i,
  // binary inputs seen by the device
  output logic [2:0] trip_side_o,
  output logic [2:0] breaker_side_o
);
  // an interrupted circuit shorts both inputs, the one pattern that means failure
  assign trip_side_o = ~trip_closed_i & ~broken_i;
  assign breaker_side_o = ~breaker_on_i & ~broken_i;
endmodule : tcs_circ_model

// ### tcs_top_test.sv
`timescale 1ns/1ps
module tcs_top_test;
  import tcs_pkg::*;
  localparam int TK = 20;
  logic ref_clk_i, resetn_i, psel_i, penable_i, pwrite_i, system_fault_i;
  logic [11:0] paddr_i;
  logic [31:0] pwdata_i, prdata_o;
  logic pready_o, pslverr_o, supervision_off_o, irq_o;
  logic [2:0] trip_fail_o, routing_mismatch_alarm_o, tsi, bsi, trip_closed, breaker_on, broken, r1;
  logic [32:0] exp_q[$];
  logic [32:0] e;
  int bad_count, n_tests, seed, idx;

  // short tick so a half-second check takes TK cycles
  tcs_top #(.TICK_CYCLES(TK)) dut (
    .ref_clk_i(ref_clk_i), .resetn_i(resetn_i), .psel_i(psel_i), .penable_i(penable_i),
    .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
    .pready_o(pready_o), .pslverr_o(pslverr_o), .trip_side_input_i(tsi), .breaker_side_input_i(bsi),
    .system_fault_i(system_fault_i), .trip_fail_o(trip_fail_o),
    .routing_mismatch_alarm_o(routing_mismatch_alarm_o), .supervision_off_o(supervision_off_o),
    .irq_o(irq_o));

  tcs_circ_model circ (.trip_closed_i(trip_closed), .breaker_on_i(breaker_on), .broken_i(broken),
    .trip_side_o(tsi), .breaker_side_o(bsi));

  initial
  begin
    ref_clk_i = 1'b0;
    forever #20 ref_clk_i = ~ref_clk_i;
  end

  task automatic results;
    $display("tests %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : results

  task automatic check(input string what, input logic [32:0] seen, input logic [32:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  // one idle edge before each setup keeps every signal to one assignment per step
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge ref_clk_i);
    psel_i <= 1'b1;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge ref_clk_i);
    penable_i <= 1'b1;
    #1;
    // no wait limit here: only the watchdog may end a stalled access
    while (pready_o !== 1'b1)
    begin
      @(posedge ref_clk_i);
      #1;
    end
    @(posedge ref_clk_i);
    psel_i <= 1'b0;
    penable_i <= 1'b0;
  endtask : apb

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr

  task automatic rd(input logic [11:0] a, input logic err, input logic [31:0] d);
    exp_q.push_back({err, d});
    apb(1'b0, a, 32'h0);
  endtask : rd

  task automatic wt(input int n);
    repeat (n) @(posedge ref_clk_i);
  endtask : wt

  // scoreboard: read data is settled by the falling edge of the access cycle
  always @(negedge ref_clk_i)
    if (psel_i && penable_i && !pwrite_i && pready_o === 1'b1 && exp_q.size() > 0)
    begin
      e = exp_q.pop_front();
      check("read", {pslverr_o, prdata_o}, e);
      if (paddr_i == TCS_OFS_STATUS)
        check("pins", {26'h0, supervision_off_o, routing_mismatch_alarm_o, trip_fail_o}, e);
    end

  initial
  begin
    repeat (20000) @(posedge ref_clk_i);
    bad_count++;
    results();
  end

  initial
  begin
    seed = 32'hFBD2EACC;
    resetn_i = 1'b0;
    psel_i = 1'b0;
    penable_i = 1'b0;
    pwrite_i = 1'b0;
    paddr_i = 12'h000;
    pwdata_i = 32'h0;
    system_fault_i = 1'b0;
    trip_closed = 3'h0;
    breaker_on = 3'h7;
    broken = 3'h0;
    wt(10);
    resetn_i <= 1'b1;
    rd(TCS_OFS_CTRL, 1'b0, 32'h0000010A);
    rd(TCS_OFS_STATUS, 1'b0, 32'h00000040);
    rd(12'h014, 1'b1, 32'h0);
    wr(TCS_OFS_IMASK, 32'h3F);
    wr(TCS_OFS_ROUTE, 32'h07);
    wr(TCS_OFS_CTRL, 32'h30B);
    wt(5);
    rd(TCS_OFS_STATUS, 1'b0, 32'h38);
    wr(TCS_OFS_CTRL, 32'h20B);
    wt(5);
    rd(TCS_OFS_STATUS, 1'b0, 32'h18);
    wr(TCS_OFS_CTRL, 32'h309);
    wt(5);
    rd(TCS_OFS_STATUS, 1'b0, 32'h0);
    rd(TCS_OFS_ISTAT, 1'b0, 32'h38);
    wr(TCS_OFS_ISTAT, 32'h3F);
    wr(TCS_OFS_ROUTE, 32'h3F);
    wr(TCS_OFS_CTRL, 32'h30B);
    #1 check("irq clear", {32'h0, irq_o}, 33'h0);
    // one random pole fails, the others sit in random healthy states
    idx = ($random(seed) & 32'h7FFFFFFF) % 3;
    r1 = 3'($random(seed));
    @(posedge ref_clk_i);
    breaker_on <= r1;
    trip_closed <= 3'($random(seed)) & ~r1;
    broken <= 3'h1 << idx;
    wt(32);
    rd(TCS_OFS_STATUS, 1'b0, 32'h0);
    wt(32);
    rd(TCS_OFS_STATUS, 1'b0, 32'h1 << idx);
    #1 check("irq", {32'h0, irq_o}, 33'h1);
    rd(TCS_OFS_ISTAT, 1'b0, 32'h1 << idx);
    wr(TCS_OFS_ISTAT, 32'h1 << idx);
    broken <= 3'h0;
    wt(32);
    rd(TCS_OFS_STATUS, 1'b0, 32'h1 << idx);
    wt(32);
    rd(TCS_OFS_STATUS, 1'b0, 32'h0);
    system_fault_i <= 1'b1;
    broken <= 3'h7;
    wt(100);
    rd(TCS_OFS_STATUS, 1'b0, 32'h0);
    broken <= 3'h0;
    system_fault_i <= 1'b0;
    // a closed trip contact is healthy with two inputs but reads as failure with one
    trip_closed <= 3'h0;
    wr(TCS_OFS_CTRL, 32'h37D);
    rd(TCS_OFS_CTRL, 1'b0, 32'h379);
    wr(TCS_OFS_CTRL, 32'h301);
    rd(TCS_OFS_CTRL, 1'b0, 32'h305);
    // the closure stays well under the two-tick delay chosen for one-input mode
    trip_closed <= 3'h7;
    wt(10);
    trip_closed <= 3'h0;
    wt(60);
    rd(TCS_OFS_STATUS, 1'b0, 32'h0);
    trip_closed <= 3'h2;
    wt(12);
    rd(TCS_OFS_STATUS, 1'b0, 32'h0);
    wt(55);
    rd(TCS_OFS_STATUS, 1'b0, 32'h2);
    trip_closed <= 3'h0;
    wt(12);
    rd(TCS_OFS_STATUS, 1'b0, 32'h2);
    wt(55);
    rd(TCS_OFS_STATUS, 1'b0, 32'h0);
    wr(TCS_OFS_CTRL, 32'h30B);
    broken <= 3'h1;
    wt(70);
    rd(TCS_OFS_STATUS, 1'b0, 32'h1);
    wr(TCS_OFS_CTRL, 32'h30A);
    wt(3);
    rd(TCS_OFS_STATUS, 1'b0, 32'h40);
    #1 check("off", {32'h0, supervision_off_o}, 33'h1);
    wr(TCS_OFS_CTRL, 32'h30B);
    wt(30);
    rd(TCS_OFS_STATUS, 1'b0, 32'h0);
    results();
  end
endmodule : tcs_top_test
